// ===== rtl/pscp_port.sv
// Serial command port of a 256-position potentiometer: wiper and stored position.
// Assumes chip select, serial clock and data pin are asynchronous to clk_in.
`timescale 1ns/1ps
module pscp_port import pscp_pkg::*; #(
    parameter int unsigned BUSY_CNT = BUSY_CYCLES,
    parameter int unsigned LOAD_CNT = LOAD_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Serial pins
    input wire logic chip_select_low_in,
    input wire logic sclk_in,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_out,
    // Device state
    output logic [POS_W-1:0] wiper_out,
    output logic [POS_W-1:0] stored_out,
    output logic loaded_out,
    output logic nv_busy_out,
    output logic standby_out
);
    initial begin
        // Busy counter is 25 bits and the load counter 16 bits wide
        if (POS_W != 8 || TAP_COUNT != 256 || BUSY_CNT < 1 || LOAD_CNT < 1 ||
            BUSY_CNT >= 2**25 || LOAD_CNT > 65536) begin
            $error("pscp_port: unsupported parameters");
        end
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic cs_lvl, cs_rise, cs_fall, sck_rise, dat_lvl;
    pscp_sync u_cs (.clk_in(clk_in), .rstn_in(rstn_in), .pin_in(chip_select_low_in),
        .level_out(cs_lvl), .rise_out(cs_rise), .fall_out(cs_fall));
    pscp_sync u_sck (.clk_in(clk_in), .rstn_in(rstn_in), .pin_in(sclk_in),
        .level_out(), .rise_out(sck_rise), .fall_out());
    pscp_sync u_dat (.clk_in(clk_in), .rstn_in(rstn_in), .pin_in(sdio_in),
        .level_out(dat_lvl), .rise_out(), .fall_out());

    // ----------------------------------------
    // State
    // ----------------------------------------
    pscp_mode_t mode_q, mode_d;
    logic [15:0] shreg_q, shreg_d;
    logic [4:0] nbits_q, nbits_d;
    logic ovf_q, ovf_d;
    logic [7:0] wiper_q, wiper_d;
    logic [7:0] store_q, store_d;
    logic [7:0] rdata_q, rdata_d;
    logic [3:0] rcnt_q, rcnt_d;
    logic [1:0] tail_q, tail_d;
    logic oe_q, oe_d;
    logic dout_q, dout_d;
    logic stby_q, stby_d;
    logic loaded_q, loaded_d;
    logic [24:0] busy_q, busy_d;
    logic busy_flag_q, busy_flag_d;
    logic [15:0] load_q, load_d;
    logic [7:0] cmd;
    logic [7:0] dat;
    logic is8, is16;

    always_comb begin
        mode_d = mode_q;
        shreg_d = shreg_q;
        nbits_d = nbits_q;
        ovf_d = ovf_q;
        wiper_d = wiper_q;
        store_d = store_q;
        rdata_d = rdata_q;
        rcnt_d = rcnt_q;
        tail_d = tail_q;
        oe_d = oe_q;
        dout_d = dout_q;
        stby_d = stby_q;
        loaded_d = loaded_q;
        busy_d = (busy_q != 25'h0) ? busy_q - 25'h1 : busy_q;
        load_d = load_q;
        is8 = (nbits_q == BITS_SHORT) && !ovf_q;
        is16 = (nbits_q == BITS_LONG) && !ovf_q;
        // 8 bit form: command in low byte; 16 bit form: command in high byte
        cmd = is16 ? shreg_q[15:8] : shreg_q[7:0];
        dat = shreg_q[7:0];
        // Power-up recall counts from reset release
        if (!loaded_q) begin
            if (load_q == 16'(LOAD_CNT - 1)) begin
                wiper_d = store_q;
                loaded_d = 1'b1;
            end else begin
                load_d = load_q + 16'h1;
            end
        end
        if (cs_fall) begin
            oe_d = 1'b0;
            stby_d = 1'b0;
            mode_d = PSCP_SHIFT;
            shreg_d = 16'h0;
            nbits_d = 5'h0;
            ovf_d = 1'b0;
        end else begin
            case (mode_q)
                PSCP_IDLE: begin
                    if (tail_q != 2'h0 && sck_rise) begin
                        tail_d = tail_q - 2'h1;
                        stby_d = (tail_q == 2'h1);
                    end
                end
                PSCP_SHIFT: begin
                    if (sck_rise && !cs_lvl) begin
                        shreg_d = {shreg_q[14:0], dat_lvl};
                        if (nbits_q == BITS_LONG) begin
                            ovf_d = 1'b1;
                        end else begin
                            nbits_d = nbits_q + 5'h1;
                        end
                    end
                    if (cs_rise) begin
                        mode_d = PSCP_IDLE;
                        stby_d = 1'b1;
                        if (is16 && cmd == CMD_WR_WIPER) begin
                            wiper_d = dat;
                        end else if (is16 && cmd == CMD_WR_STORE) begin
                            store_d = dat;
                            busy_d = 25'(BUSY_CNT);
                        end else if ((is8 || is16) && cmd == CMD_SAVE) begin
                            store_d = wiper_q;
                            busy_d = 25'(BUSY_CNT);
                        end else if ((is8 || is16) && cmd == CMD_RECALL) begin
                            wiper_d = store_q;
                        end else if ((is8 || is16) && (cmd == CMD_RD_STORE || cmd == CMD_RD_WIPER)) begin
                            rdata_d = (cmd == CMD_RD_WIPER) ? wiper_q : store_q;
                            rcnt_d = 4'h0;
                            oe_d = 1'b1;
                            stby_d = 1'b0;
                            mode_d = PSCP_READ;
                        end
                        // Unknown command bytes fall through unchanged
                    end
                end
                PSCP_READ: begin
                    if (sck_rise) begin
                        // First edge is a gap; bit n appears on edge n+2
                        if (rcnt_q != 4'h0) begin
                            dout_d = rdata_q[7];
                            rdata_d = {rdata_q[6:0], 1'b0};
                        end
                        if (rcnt_q == 4'h8) begin
                            mode_d = PSCP_IDLE;
                            tail_d = 2'(STANDBY_CLKS);
                        end
                        rcnt_d = rcnt_q + 4'h1;
                    end
                end
                default: mode_d = PSCP_IDLE;
            endcase
        end
        // Flag follows the counter's next value so the output stays a plain flop
        busy_flag_d = (busy_d != 25'h0);
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            mode_q <= PSCP_IDLE;
            shreg_q <= 16'h0;
            nbits_q <= 5'h0;
            ovf_q <= 1'b0;
            wiper_q <= MID_SCALE;
            rdata_q <= 8'h0;
            rcnt_q <= 4'h0;
            tail_q <= 2'h0;
            oe_q <= 1'b0;
            dout_q <= 1'b0;
            stby_q <= 1'b1;
            loaded_q <= 1'b0;
            busy_q <= 25'h0;
            busy_flag_q <= 1'b0;
            load_q <= 16'h0;
        end else begin
            mode_q <= mode_d;
            shreg_q <= shreg_d;
            nbits_q <= nbits_d;
            ovf_q <= ovf_d;
            wiper_q <= wiper_d;
            rdata_q <= rdata_d;
            rcnt_q <= rcnt_d;
            tail_q <= tail_d;
            oe_q <= oe_d;
            dout_q <= dout_d;
            stby_q <= stby_d;
            loaded_q <= loaded_d;
            busy_q <= busy_d;
            busy_flag_q <= busy_flag_d;
            load_q <= load_d;
        end
    end

    // ----------------------------------------
    // Non-volatile store
    // ----------------------------------------
    // Store models non-volatile memory: reset does not disturb it
    logic store_init_q = 1'b0;
    always_ff @(posedge clk_in) begin
        if (!store_init_q) begin
            store_q <= MID_SCALE;
            store_init_q <= 1'b1;
        end else begin
            store_q <= store_d;
            store_init_q <= 1'b1;
        end
    end
    assign sdio_out = dout_q;
    assign sdio_oe_out = oe_q;
    assign wiper_out = wiper_q;
    assign stored_out = store_q;
    assign loaded_out = loaded_q;
    assign nv_busy_out = busy_flag_q;
    assign standby_out = stby_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_rd_no_move: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_READ) |=> $stable(wiper_q) || !loaded_q)
        else $error("wiper moved during read out");
    chk_oe_release: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cs_fall |=> !sdio_oe_out)
        else $error("data line not released at chip select fall");
    chk_wr_wiper: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && is16 && cmd == CMD_WR_WIPER) |=> wiper_q == $past(shreg_q[7:0]))
        else $error("wiper write lost");
    chk_store_only: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && is16 && cmd == CMD_WR_STORE && loaded_q) |=> $stable(wiper_q))
        else $error("store write moved the wiper");
    chk_bad_count: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && !is8 && !is16 && loaded_q) |=> $stable(wiper_q) && $stable(store_q))
        else $error("command executed with wrong bit count");
    chk_read_oe: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && (is8 || is16) && cmd == CMD_RD_WIPER) |=> sdio_oe_out)
        else $error("read did not drive data line");
    chk_power_load: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(loaded_q) |-> wiper_q == store_q || $past(cs_rise))
        else $error("power up recall wrong");
    chk_no_shift_high: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_lvl && !cs_fall) |=> $stable(nbits_q))
        else $error("bits taken with chip select high");
    chk_standby: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_READ) |-> !standby_out)
        else $error("standby during read out");
    chk_wr_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && is16 && cmd == CMD_WR_STORE) |=> stored_out == $past(shreg_q[7:0]))
        else $error("store write lost");
    chk_save_copy: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && (is8 || is16) && cmd == CMD_SAVE) |=> stored_out == $past(wiper_q))
        else $error("wiper not copied to store");
    chk_recall_copy: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && (is8 || is16) && cmd == CMD_RECALL) |=> wiper_out == $past(store_q))
        else $error("store not copied to wiper");
    chk_busy_start: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_q == PSCP_SHIFT && cs_rise && is16 && cmd == CMD_WR_STORE) |=> nv_busy_out)
        else $error("store write did not raise busy");
    chk_frame_awake: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cs_fall |=> !standby_out)
        else $error("standby while chip select low");
    cov_write: cover property (@(posedge clk_in) mode_q == PSCP_SHIFT && cs_rise && is16 && cmd == CMD_WR_WIPER);
    cov_read: cover property (@(posedge clk_in) mode_q == PSCP_READ && rcnt_q == 4'h8 && sck_rise);
    cov_save: cover property (@(posedge clk_in) mode_q == PSCP_SHIFT && cs_rise && is8 && cmd == CMD_SAVE);
    cov_recall: cover property (@(posedge clk_in) mode_q == PSCP_SHIFT && cs_rise && is8 && cmd == CMD_RECALL);
    cov_refused: cover property (@(posedge clk_in) mode_q == PSCP_SHIFT && cs_rise && ovf_q);
endmodule : pscp_port

// ===== rtl/pscp_pkg.sv
// Constants and types of the potentiometer serial command port.
// Assumes a single 25 MHz system clock; the serial pins are asynchronous to it.
// Contract
// - Serial input is taken only while chip select is low, one bit per rising clock.
// - An 8 or 16 bit word executes when chip select rises; input then stops.
// - Any other bit count executes nothing at chip select rise.
// - Sixteen bit word is command byte then data byte, both MSB first.
// - Command 0x00 writes wiper, 0x10 writes the stored position.
// - 0x20 wiper to store, 0x30 store to wiper, 0x28 reads store, 0x68 reads wiper.
// - Write commands need exactly sixteen clocks.
// - Copy and read accept 8 or 16 clocks; trailing data byte ignored.
// - Wiper write loads the data byte as the wiper position.
// - Wiper register is 8 bits, selecting one of 256 taps.
// - Store write changes only the stored value, never the wiper.
// - Copy wiper to store saves the wiper; never triggered automatically.
// - Copy store to wiper loads the stored value into the wiper.
// - After power up the stored position loads into the wiper within 5 us.
// - After an accepted read, data line drives the register out MSB first.
// - Read data starts on the second rising clock after chip select rises.
// - Next falling chip select releases the data line to input.
// - Reading the wiper leaves the wiper position unchanged.
// - Standby while chip select high; after a read, two clocks after last bit.
// - Store holds mid scale as shipped.
// - A store write takes up to 20 ms before power removal or next store.
package pscp_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned POS_W = 8;
    localparam int unsigned TAP_COUNT = 256;
    localparam logic [7:0] MID_SCALE = 8'h80;
    localparam logic [7:0] CMD_WR_WIPER = 8'h00;
    localparam logic [7:0] CMD_WR_STORE = 8'h10;
    localparam logic [7:0] CMD_SAVE = 8'h20;
    localparam logic [7:0] CMD_RECALL = 8'h30;
    localparam logic [7:0] CMD_RD_STORE = 8'h28;
    localparam logic [7:0] CMD_RD_WIPER = 8'h68;
    localparam logic [4:0] BITS_SHORT = 5'h08;
    localparam logic [4:0] BITS_LONG = 5'h10;
    localparam int unsigned LOAD_TIME_NS = 5000;
    localparam int unsigned LOAD_CYCLES = LOAD_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned BUSY_TIME_MS = 20;
    localparam int unsigned BUSY_CYCLES = BUSY_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned STANDBY_CLKS = 2;
    typedef enum logic [1:0] {PSCP_IDLE, PSCP_SHIFT, PSCP_READ} pscp_mode_t;
endpackage : pscp_pkg

// ===== rtl/pscp_sync.sv
// Two-stage synchroniser with edge outputs for one asynchronous pin.
// Assumes the pin is slow compared to clk_in.
`timescale 1ns/1ps
module pscp_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Pin
    input wire logic pin_in,
    // Synchronised level and edges
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // Idle level high so chip select does not fake an edge at reset
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;
endmodule : pscp_sync

// ===== dv/pscp_host_model.sv
// Host side model of the serial pins: chip select, serial clock and data line.
// Assumes clk_in is the 25 MHz system clock; one serial clock period is 8 of its cycles.
`timescale 1ns/1ps
module pscp_host_model (
    // Clock
    input wire logic clk_in,
    // Device side: data line and standby state
    input wire logic sdio_out_in,
    input wire logic sdio_oe_in,
    input wire logic stby_in,
    // Serial pins
    output logic cs_low_out,
    output logic sclk_out,
    output logic sdio_out
);
    logic host_bit;
    initial begin
        cs_low_out = 1'b1;
        sclk_out = 1'b0;
        host_bit = 1'b0;
    end
    // Wire level: the device wins while it drives; a released line never keeps the last bit
    assign sdio_out = sdio_oe_in ? sdio_out_in : host_bit;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    // Whole word under one unbroken low chip select, MSB first; sclk idles low outside frames
    task automatic frame(input logic [16:0] bits, input int n);
        cs_low_out = 1'b0;
        tick(4);
        for (int i = n - 1; i >= 0; i--) begin
            host_bit = bits[i];
            tick(4);
            sclk_out = 1'b1;
            tick(4);
            sclk_out = 1'b0;
        end
        tick(4);
        cs_low_out = 1'b1;
        host_bit = ~host_bit;
        tick(8);
    endtask : frame
    // Read out with chip select high: 9 rises for the data, 2 more for standby
    task automatic read_out(output logic [7:0] v, output logic oe_hold, output logic oe_rel,
        output logic sb_mid, output logic sb_end);
        for (int r = 1; r <= 11; r++) begin
            sclk_out = 1'b1;
            tick(4);
            sclk_out = 1'b0;
            tick(4);
            if (r >= 2 && r <= 9) v[9 - r] = sdio_out_in;
            if (r == 10) sb_mid = stby_in;
        end
        // Standby seen before chip select falls, or the next frame would hide it
        sb_end = stby_in;
        oe_hold = sdio_oe_in;
        cs_low_out = 1'b0;
        tick(6);
        oe_rel = sdio_oe_in;
        cs_low_out = 1'b1;
        tick(8);
    endtask : read_out
endmodule : pscp_host_model

// ===== dv/pscp_port_tb.sv
// Self-checking bench of the serial command port, random words plus refused frames.
// Assumes the host model drives all serial pins; store busy time shortened to 50 cycles.
`timescale 1ns/1ps
module pscp_port_tb;
    import pscp_pkg::*;
    logic clk_in, rstn_in, cs_low, sclk, sdio, sdio_out, sdio_oe, loaded, busy, stby, oh, orl, sm, se;
    int bad_n [4] = '{8, 12, 15, 17};
    logic [7:0] wiper, stored, exp_w, exp_s, v, a;
    logic [31:0] seed;
    int n_mismatch, compares, k;
    pscp_port #(.BUSY_CNT(50)) pscp_port_inst (.clk_in(clk_in), .rstn_in(rstn_in),
        .chip_select_low_in(cs_low), .sclk_in(sclk), .sdio_in(sdio), .sdio_out(sdio_out),
        .sdio_oe_out(sdio_oe), .wiper_out(wiper), .stored_out(stored), .loaded_out(loaded),
        .nv_busy_out(busy), .standby_out(stby));
    pscp_host_model pscp_host_model_inst (.clk_in(clk_in), .sdio_out_in(sdio_out),
        .sdio_oe_in(sdio_oe), .stby_in(stby), .cs_low_out(cs_low), .sclk_out(sclk), .sdio_out(sdio));
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // Expectation and checking
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic void upd(input logic [7:0] c, input logic [7:0] d, input int n);
        if (n == 16 && c == CMD_WR_WIPER) exp_w = d;
        if (n == 16 && c == CMD_WR_STORE) exp_s = d;
        if ((n == 8 || n == 16) && c == CMD_SAVE) exp_s = exp_w;
        if ((n == 8 || n == 16) && c == CMD_RECALL) exp_w = exp_s;
    endfunction : upd
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic send(input logic [7:0] c, input logic [7:0] d, input int n);
        pscp_host_model_inst.frame(17'({c, d, 1'b0} >> (17 - n)), n);
        upd(c, d, n);
        chk("wiper", exp_w, wiper);
        chk("stored", exp_s, stored);
    endtask : send
    task automatic rd(input logic [7:0] c, input int n, input logic [7:0] e);
        send(c, 8'(xs()), n);
        chk("oe_after_cmd", 8'h01, {7'h00, sdio_oe});
        pscp_host_model_inst.read_out(v, oh, orl, sm, se);
        chk("read_data", e, v);
        chk("standby_mid", 8'h00, {7'h00, sm});
        chk("standby", 8'h01, {7'h00, se});
        chk("oe_hold", 8'h01, {7'h00, oh});
        chk("oe_release", 8'h00, {7'h00, orl});
        chk("wiper_kept", exp_w, wiper);
    endtask : rd
    task automatic wait_nv();
        for (k = 0; k < 200 && busy !== 1'b0; k++) begin
            @(posedge clk_in);
            #1;
        end
        chk("nv_busy", 8'h00, {7'h00, busy});
        if (busy !== 1'b0) stop_test();
    endtask : wait_nv
    // Reset for four cycles, then the recall must be done within 5 us
    task automatic do_reset();
        rstn_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        for (k = 0; k < int'(LOAD_CYCLES) + 2 && loaded !== 1'b1; k++) begin
            @(posedge clk_in);
            #1;
        end
        chk("loaded", 8'h01, {7'h00, loaded});
        if (loaded !== 1'b1) stop_test();
    endtask : do_reset
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hbbf4a512;
        n_mismatch = 0;
        compares = 0;
        exp_w = MID_SCALE;
        exp_s = MID_SCALE;
        do_reset();
        chk("stored_shipped", MID_SCALE, stored);
        chk("wiper_recalled", MID_SCALE, wiper);
        for (int i = 0; i < 6; i++) begin
            a = 8'(xs());
            send(CMD_WR_WIPER, a, 16);
            chk("standby_idle", 8'h01, {7'h00, stby});
            send(CMD_WR_STORE, 8'(xs()), 16);
            chk("nv_busy_set", 8'h01, {7'h00, busy});
            wait_nv();
            rd(CMD_RD_WIPER, (i % 2 == 0) ? 8 : 16, exp_w);
            rd(CMD_RD_STORE, (i % 2 == 0) ? 16 : 8, exp_s);
            send(CMD_SAVE, 8'(xs()), (i % 2 == 0) ? 8 : 16);
            wait_nv();
            send(CMD_WR_WIPER, ~a, 16);
            send(CMD_RECALL, 8'(xs()), (i % 2 == 0) ? 16 : 8);
        end
        // Reset in mid run: the wiper must come back from the store, not from mid scale
        send(CMD_WR_STORE, ~exp_w, 16);
        wait_nv();
        do_reset();
        exp_w = exp_s;
        chk("wiper_reload", exp_w, wiper);
        // Wrong bit counts and an unknown command change nothing
        foreach (bad_n[j]) send(CMD_WR_WIPER, ~exp_w, bad_n[j]);
        send(CMD_WR_STORE, ~exp_s, 8);
        send(8'h55, ~exp_w, 16);
        send(CMD_SAVE, 8'h00, 7);
        rd(CMD_RD_WIPER, 16, exp_w);
        stop_test();
    end
endmodule : pscp_port_tb
